// *** rtl/cfe_top.sv ***
// Purpose: register block for transmit buffer selection, acceptance
//          mode and hit, bus-off hold and error counter access
// Assumes: APB slave on mclk; handshake and engine inputs synchronous
// Notes:   zero-wait APB; read data is captured in the setup cycle
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "cfe_cfg.svh"
module cfe_top
   import cfe_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   input  wire logic        initModeRequest,
   input  wire logic        initModeAcknowledge,
   input  wire logic        sleepModeRequest,
   input  wire logic        sleepModeAcknowledge,
   input  wire logic [2:0]  transmitEmptyFlags,
   input  wire logic        winAccessReq,
   output var  logic [2:0]  winSelect,
   output var  logic        winGrant,
   output var  logic        winBlocked,
   input  wire logic        rxMsgValid,
   input  wire logic [2:0]  rxFilterHit,
   output var  logic        fgReload,
   output var  logic [1:0]  acceptanceMode,
   input  wire logic        busOffEnter,
   output var  logic        busOffHeld,
   output var  logic        recoveryRequest,
   input  wire logic [7:0]  rxErrorCount,
   input  wire logic [7:0]  txErrorCount,
   output var  logic        irq
);

   // -------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------
   logic [2:0]      tbsel_r;
   logic [1:0]      acceptance_mode_field_r;
   logic [2:0]      hit_r;
   logic            bus_off_recovery_on_request_r;
   cfe_boff_type    boff_r;
   logic [2:0]      irqStat_r;
   logic [2:0]      irqMask_r;
   logic [31:0]     prdata_r;
   logic            pready_r;
   logic            pslverr_r;
   logic [2:0]      winSelect_r;
   logic            winGrant_r;
   logic            winBlocked_r;
   logic            fgReload_r;
   logic            recoveryRequest_r;
   logic            irq_r;

   logic            initMode;
   logic            noInit;
   logic            cntReadOk;
   logic            setupCyc;
   logic            wrEn;
   logic [2:0]      lowSel;
   logic            acceptMsg;
   logic            boffClear;
   logic [2:0]      irqSet;
   logic [2:0]      irqClr;
   logic [7:0]      rdByte;
   logic            rdErr;

   cfe_win_if win ();

   // -------------------------------------------------------------
   // mode qualifiers and bus strobes
   // -------------------------------------------------------------
   assign initMode  = initModeRequest & initModeAcknowledge;
   assign noInit    = ~initModeRequest & ~initModeAcknowledge;
   assign cntReadOk = initMode
                    | (sleepModeRequest & sleepModeAcknowledge);
   assign setupCyc  = psel & ~penable;
   // writes land only at the completing access edge
   assign wrEn      = psel & penable & pready_r & pwrite;

   assign lowSel = tbsel_r & (~tbsel_r + 3'h1);

   // -------------------------------------------------------------
   // transmit window gate
   // -------------------------------------------------------------
   assign win.selOneHot = lowSel;
   assign win.txEmpty   = transmitEmptyFlags;
   assign win.accReq    = winAccessReq;

   cfe_win_gate u_gate (
      .win (win.gate)
   );

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         winSelect_r  <= 3'h0;
         winGrant_r   <= 1'b0;
         winBlocked_r <= 1'b0;
      end else begin
         winSelect_r  <= lowSel;
         winGrant_r   <= win.accGrant;
         winBlocked_r <= winAccessReq & ~win.accGrant;
      end
   end

   // -------------------------------------------------------------
   // buffer select register
   // -------------------------------------------------------------
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         tbsel_r <= `CFE_TBSEL_RST;
      // held at reset in init mode
      end else if (initMode) begin
         tbsel_r <= `CFE_TBSEL_RST;
      end else if (wrEn && paddr == `CFE_OFF_TBSEL && noInit) begin
         tbsel_r <= pwdata[2:0];
      end
   end

   // -------------------------------------------------------------
   // acceptance control
   // -------------------------------------------------------------
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         acceptance_mode_field_r <= `CFE_ACCEPTANCE_MODE_FIELD_RST;
      // mode written only in init mode
      end else if (wrEn && paddr == `CFE_OFF_IDAC && initMode) begin
         acceptance_mode_field_r <= pwdata[`CFE_ACCEPTANCE_MODE_FIELD_MSB:`CFE_ACCEPTANCE_MODE_FIELD_LSB];
      end
   end

   assign acceptMsg = rxMsgValid && (cfe_accmode_type'(acceptance_mode_field_r) != ACC_CLOSED);

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         hit_r      <= `CFE_HIT_RST;
         fgReload_r <= 1'b0;
      end else begin
         fgReload_r <= acceptMsg;
         if (acceptMsg) begin
            hit_r <= rxFilterHit;
         end
      end
   end

   // -------------------------------------------------------------
   // bus-off hold
   // -------------------------------------------------------------
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         bus_off_recovery_on_request_r <= 1'b0;
      end else if (wrEn && paddr == `CFE_OFF_CTRL) begin
         bus_off_recovery_on_request_r <= pwdata[`CFE_BUS_OFF_RECOVERY_ON_REQUEST_BIT];
      end
   end

   // write of one clears, zero ignored
   assign boffClear = wrEn && paddr == `CFE_OFF_MISC
                    && pwdata[`CFE_BUS_OFF_HELD_FLAG_BIT];

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         boff_r            <= BOFF_RUN;
         recoveryRequest_r <= 1'b0;
      end else begin
         recoveryRequest_r <= 1'b0;
         case (boff_r)
            BOFF_RUN: begin
               if (busOffEnter && bus_off_recovery_on_request_r) begin
                  boff_r <= BOFF_HOLD;
               end
            end
            BOFF_HOLD: begin
               // a new bus-off in the clearing cycle keeps the hold
               if (boffClear && !busOffEnter) begin
                  boff_r            <= BOFF_RUN;
                  recoveryRequest_r <= 1'b1;
               end
            end
            default: begin
               boff_r <= BOFF_RUN;
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // interrupts
   // -------------------------------------------------------------
   assign irqSet = {winAccessReq & ~win.accGrant, acceptMsg,
                    busOffEnter};
   assign irqClr = (wrEn && paddr == `CFE_OFF_IRQSTAT) ? pwdata[2:0]
                                                       : 3'h0;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         irqStat_r <= `CFE_IRQ_RST;
      end else begin
         // set beats clear in the same cycle
         irqStat_r <= (irqStat_r & ~irqClr) | irqSet;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         irqMask_r <= `CFE_IRQ_RST;
      end else if (wrEn && paddr == `CFE_OFF_IRQMASK) begin
         irqMask_r <= pwdata[2:0];
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(((irqStat_r & ~irqClr) | irqSet) & irqMask_r);
      end
   end

   // -------------------------------------------------------------
   // read mux
   // -------------------------------------------------------------
   always_comb begin
      rdByte = 8'h00;
      rdErr  = 1'b0;
      case (paddr)
         `CFE_OFF_TBSEL:   rdByte = {5'h00, lowSel};
         `CFE_OFF_IDAC:    rdByte = {2'h0, acceptance_mode_field_r, 1'b0, hit_r};
         `CFE_OFF_MISC:    rdByte = {7'h00, boff_r == BOFF_HOLD};
         `CFE_OFF_RXERR: begin
            rdByte = cntReadOk ? rxErrorCount : 8'h00;
            rdErr  = ~cntReadOk;
         end
         `CFE_OFF_TXERR: begin
            rdByte = cntReadOk ? txErrorCount : 8'h00;
            rdErr  = ~cntReadOk;
         end
         `CFE_OFF_CTRL:    rdByte = {7'h00, bus_off_recovery_on_request_r};
         `CFE_OFF_IRQSTAT: rdByte = {5'h00, irqStat_r};
         `CFE_OFF_IRQMASK: rdByte = {5'h00, irqMask_r};
         default:          rdErr  = 1'b1;
      endcase
   end

   // -------------------------------------------------------------
   // apb answer
   // -------------------------------------------------------------
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         prdata_r  <= 32'h0000_0000;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else if (setupCyc) begin
         prdata_r  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rdByte};
         pready_r  <= 1'b1;
         pslverr_r <= pwrite ? (rdErr & (paddr != `CFE_OFF_RXERR)
                               & (paddr != `CFE_OFF_TXERR)) : rdErr;
      end else begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end
   end

   assign prdata          = prdata_r;
   assign pready          = pready_r;
   assign pslverr         = pslverr_r;
   assign winSelect       = winSelect_r;
   assign winGrant        = winGrant_r;
   assign winBlocked      = winBlocked_r;
   assign fgReload        = fgReload_r;
   assign acceptanceMode  = acceptance_mode_field_r;
   assign busOffHeld      = boff_r[1];
   assign recoveryRequest = recoveryRequest_r;
   assign irq             = irq_r;

   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   tbsel_held_a: assert property (
      initMode |=> tbsel_r == 3'h0)
      else $error("select not held in init mode");

   tbsel_wrgate_a: assert property (
      wrEn && paddr == `CFE_OFF_TBSEL && !noInit && !initMode
      |=> $stable(tbsel_r))
      else $error("select written during init handshake");

   tbsel_read_a: assert property (
      setupCyc && !pwrite && paddr == `CFE_OFF_TBSEL
      |=> pready && prdata[7:0] == {5'h00, $past(lowSel)})
      else $error("select readback not lowest bit");

   win_select_a: assert property (
      ##1 winSelect == $past(tbsel_r & (~tbsel_r + 3'h1)))
      else $error("window maps wrong buffer");

   win_blocked_a: assert property (
      winAccessReq && (lowSel & ~transmitEmptyFlags) != 3'h0
      |=> !winGrant && winBlocked)
      else $error("scheduled buffer accessed");

   win_none_a: assert property (
      winAccessReq && tbsel_r == 3'h0 |=> !winGrant ##0 winBlocked)
      else $error("access granted with no selection");

   idac_wrgate_a: assert property (
      wrEn && paddr == `CFE_OFF_IDAC && !initMode |=> $stable(acceptance_mode_field_r))
      else $error("mode written outside init");

   filter_closed_a: assert property (
      acceptanceMode == 2'h3 |=> !fgReload)
      else $error("closed filter reloaded buffer");

   hit_update_a: assert property (
      hit_r == (fgReload ? $past(rxFilterHit) : $past(hit_r)))
      else $error("hit index not tied to reload");

   bus_off_held_flag_set_a: assert property (
      busOffEnter && bus_off_recovery_on_request_r |=> busOffHeld [*2] or
      (busOffHeld ##1 recoveryRequest))
      else $error("bus-off hold not entered");

   bus_off_held_flag_clr_a: assert property (
      busOffHeld && boffClear && !busOffEnter
      |=> !busOffHeld && recoveryRequest ##1 !recoveryRequest)
      else $error("hold clear or recovery pulse wrong");

   errcnt_gate_a: assert property (
      setupCyc && !pwrite && !cntReadOk
      && (paddr == `CFE_OFF_RXERR || paddr == `CFE_OFF_TXERR)
      |=> pslverr && prdata == 32'h0000_0000)
      else $error("error count served out of mode");

   errcnt_tx_a: assert property (
      setupCyc && !pwrite && cntReadOk && paddr == `CFE_OFF_TXERR
      |=> prdata[7:0] == $past(txErrorCount) && !pslverr)
      else $error("transmit count not returned");

   reserved_zero_a: assert property (
      pready |-> prdata[31:8] == 24'h00_0000)
      else $error("reserved bits not zero");

endmodule : cfe_top
`default_nettype wire

// *** rtl/cfe_cfg.svh ***
// Purpose: offsets, field positions and reset values of the CAN
//          buffer-select, filter-control and error-count register block
// Assumes: 32-bit APB, one aligned word per register, data in bits 7:0
// Notes:   included by every design file that decodes registers
//
// Summary of operation
// - buffer select is forced to reset while init mode requested and acknowledged.
// - buffer select is writable only with init request and acknowledge both low.
// - buffer select reads back only its lowest set bit.
// - lowest set select bit picks the buffer mapped into the window.
// - window access is blocked while the selected buffer is scheduled.
// - with no buffer selected every window access is refused.
// - acceptance control writable only in init mode; hit bits read-only.
// - mode field 5:4 selects 2x32, 4x16, 8x8 filters or closed.
// - in closed mode no message is accepted into the foreground buffer.
// - hit field 2:0 holds the index of the matching filter.
// - hit field is refreshed whenever the foreground buffer is reloaded.
// - with recovery-on-request, entering bus-off sets the hold bit and holds.
// - writing one clears the hold bit and requests recovery; zero ignored.
// - receive error count is read-only, valid in sleep or init mode.
// - transmit error count is read-only, valid in sleep or init mode.
// - set empty flag means free buffer; clear means scheduled for sending.
`ifndef CFE_CFG_SVH
`define CFE_CFG_SVH

`define CFE_OFF_TBSEL    8'h00
`define CFE_OFF_IDAC     8'h04
`define CFE_OFF_MISC     8'h08
`define CFE_OFF_RXERR    8'h0C
`define CFE_OFF_TXERR    8'h10
`define CFE_OFF_CTRL     8'h14
`define CFE_OFF_IRQSTAT  8'h18
`define CFE_OFF_IRQMASK  8'h1C

`define CFE_ACCEPTANCE_MODE_FIELD_LSB     4
`define CFE_ACCEPTANCE_MODE_FIELD_MSB     5
`define CFE_BUS_OFF_HELD_FLAG_BIT   0
`define CFE_BUS_OFF_RECOVERY_ON_REQUEST_BIT     0

`define CFE_IRQ_BUSOFF   0
`define CFE_IRQ_RXLOAD   1
`define CFE_IRQ_WINBLK   2

`define CFE_TBSEL_RST    3'h0
`define CFE_ACCEPTANCE_MODE_FIELD_RST     2'h0
`define CFE_HIT_RST      3'h0
`define CFE_IRQ_RST      3'h0

`endif

// *** rtl/cfe_pkg.sv ***
// Purpose: shared types of the CAN select/filter/error-count block
// Assumes: constants live in cfe_cfg.svh
// Notes:   types only
package cfe_pkg;

   typedef enum logic [1:0] {
      BOFF_RUN  = 2'b01,
      BOFF_HOLD = 2'b10
   } cfe_boff_type;

   typedef enum logic [1:0] {
      ACC_TWO32   = 2'h0,
      ACC_FOUR16  = 2'h1,
      ACC_EIGHT8  = 2'h2,
      ACC_CLOSED  = 2'h3
   } cfe_accmode_type;

endpackage : cfe_pkg

// *** rtl/cfe_win_if.sv ***
// Purpose: carries buffer selection and window access between modules
// Assumes: single clock domain, purely combinational signals
// Notes:   ctrl side is the register block, gate side the window check
`timescale 1ns/1ns
`default_nettype none
interface cfe_win_if;
   logic [2:0] selOneHot;
   logic [2:0] txEmpty;
   logic       accReq;
   logic       accGrant;

   modport ctrl (output selOneHot, output txEmpty, output accReq,
                 input accGrant);
   modport gate (input selOneHot, input txEmpty, input accReq,
                 output accGrant);
endinterface : cfe_win_if
`default_nettype wire

// *** rtl/cfe_win_gate.sv ***
// Purpose: decides whether a transmit window access may proceed
// Assumes: selOneHot has at most one bit set
// Notes:   combinational; the caller registers the result
`timescale 1ns/1ns
`default_nettype none
module cfe_win_gate (
   cfe_win_if.gate win
);
   logic scheduledSel;

   // cleared empty flag marks a scheduled buffer
   assign scheduledSel = |(win.selOneHot & ~win.txEmpty);

   assign win.accGrant = win.accReq & (|win.selOneHot) & ~scheduledSel;
endmodule : cfe_win_gate
`default_nettype wire

// *** verif/cfe_can_peer.sv ***
// Purpose: stand-in for the protocol engine and bus side of the block
// Assumes: one clock; the bench calls the tasks right after a clock edge
// Notes:   hit index is inverted outside a message so stale data shows
`timescale 1ns/1ns
`default_nettype none
module cfe_can_peer (
   input  wire logic       mclk,
   output var  logic       rxMsgValid,
   output var  logic [2:0] rxFilterHit,
   output var  logic       busOffEnter,
   output var  logic [2:0] transmitEmptyFlags,
   output var  logic [7:0] rxErrorCount,
   output var  logic [7:0] txErrorCount
);
   initial begin
      rxMsgValid = 1'b0;
      rxFilterHit = 3'h5;
      busOffEnter = 1'b0;
      transmitEmptyFlags = 3'h7;
      rxErrorCount = 8'h00;
      txErrorCount = 8'h00;
   end
   task automatic send_msg(input logic [2:0] hit);
      @(posedge mclk);
      rxMsgValid  <= 1'b1;
      rxFilterHit <= hit;
      @(posedge mclk);
      rxMsgValid  <= 1'b0;
      rxFilterHit <= ~hit;
   endtask : send_msg
   task automatic enter_bus_off;
      @(posedge mclk);
      busOffEnter <= 1'b1;
      @(posedge mclk);
      busOffEnter <= 1'b0;
   endtask : enter_bus_off
   task automatic set_state(input logic [2:0] empty,
                            input logic [7:0] rxc,
                            input logic [7:0] txc);
      @(posedge mclk);
      transmitEmptyFlags <= empty;
      rxErrorCount <= rxc;
      txErrorCount <= txc;
   endtask : set_state
endmodule : cfe_can_peer
`default_nettype wire

// *** verif/tb_top.sv ***
// Purpose: self-checking bench of the select/filter/error-count block
// Assumes: zero-wait APB slave, registers in bits 7:0
// Notes:   random data from a fixed seed, corner cases written by hand
`timescale 1ns/1ns
`default_nettype none
`include "cfe_cfg.svh"
module tb_top
   import cfe_pkg::*;
;
   logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic init_mode_request, init_mode_acknowledge, sleep_mode_request, sleep_mode_acknowledge, winReq, winGrant, winBlocked;
   logic rxValid, fgReload, boEnter, busOffHeld, recoveryRequest, e;
   logic [2:0] txEmpty, rxHit, winSelect, sel, hit, h;
   logic [1:0] acceptanceMode;
   logic [7:0] rxCnt, txCnt, d;
   int failCount, nTests, seed, i, k;
   cfe_top cfe_top_i (.mclk(mclk), .sys_rst(sys_rst), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .initModeRequest(init_mode_request), .initModeAcknowledge(init_mode_acknowledge),
      .sleepModeRequest(sleep_mode_request), .sleepModeAcknowledge(sleep_mode_acknowledge),
      .transmitEmptyFlags(txEmpty), .winAccessReq(winReq),
      .winSelect(winSelect), .winGrant(winGrant), .winBlocked(winBlocked),
      .rxMsgValid(rxValid), .rxFilterHit(rxHit), .fgReload(fgReload),
      .acceptanceMode(acceptanceMode), .busOffEnter(boEnter),
      .busOffHeld(busOffHeld), .recoveryRequest(recoveryRequest),
      .rxErrorCount(rxCnt), .txErrorCount(txCnt), .irq(irq));
   cfe_can_peer cfe_can_peer_i (.mclk(mclk), .rxMsgValid(rxValid),
      .rxFilterHit(rxHit), .busOffEnter(boEnter),
      .transmitEmptyFlags(txEmpty), .rxErrorCount(rxCnt),
      .txErrorCount(txCnt));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic finish_test;
      $display("checks %0d mismatches %0d", nTests, failCount);
      if (failCount == 0 && nTests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input string name, input logic [31:0] exp,
                      input logic [31:0] got);
      nTests++;
      if (got !== exp) begin
         failCount++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // master holds the request until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         failCount++;
         finish_test();
      end
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      apb(1'b1, a, {$random(seed)} & 32'hFFFF_FF00 | {24'h0, v});
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] v,
                     input logic err);
      apb(1'b0, a, 32'h0);
      chk("prdata", {24'h0, v}, r);
      chk("pslverr", {31'h0, err}, {31'h0, e});
   endtask : rd
   task automatic mode(input logic ir, ia, sr, sa);
      @(posedge mclk);
      init_mode_request <= ir;
      init_mode_acknowledge <= ia;
      sleep_mode_request <= sr;
      sleep_mode_acknowledge <= sa;
   endtask : mode
   // one window request, answered in the next cycle
   task automatic win(input logic grant);
      @(posedge mclk);
      winReq <= 1'b1;
      @(posedge mclk);
      winReq <= 1'b0;
      @(posedge mclk);
      chk("winGrant", {31'h0, grant}, {31'h0, winGrant});
      chk("winBlocked", {31'h0, !grant}, {31'h0, winBlocked});
   endtask : win
   task automatic waitChk(input string name, input logic exp);
      repeat (3) @(posedge mclk);
      chk(name, {31'h0, exp}, {31'h0, (name == "irq") ? irq : busOffHeld});
   endtask : waitChk
   function automatic logic [2:0] lowBit(input logic [2:0] v);
      return v & (~v + 3'h1);
   endfunction : lowBit
   // ----------------------------------------------------------------
   // clock, watchdog, main sequence
   // ----------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      failCount++;
      finish_test();
   end
   initial begin
      {psel, penable, pwrite, winReq, init_mode_request, init_mode_acknowledge, sleep_mode_request, sleep_mode_acknowledge} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      seed = 8;
      failCount = 0;
      nTests = 0;
      hit = 3'h0;
      sys_rst = 1'b1;
      repeat (8) @(posedge mclk);
      sys_rst <= 1'b0;
      for (i = 0; i < 8; i++) begin
         rd(8'(i * 4), 8'h00, i == 3 || i == 4);
      end
      rd(8'h20, 8'h00, 1'b1);
      for (i = 0; i < 16; i++) begin
         d = 8'($random(seed));
         if (i < 8) d[2:0] = 3'(i);
         sel = lowBit(d[2:0]);
         cfe_can_peer_i.set_state(3'($random(seed)), 8'(i), 8'(i));
         wr(`CFE_OFF_TBSEL, d);
         rd(`CFE_OFF_TBSEL, {5'h0, sel}, 1'b0);
         chk("winSelect", {29'h0, sel}, {29'h0, winSelect});
         win((sel & txEmpty) != 3'h0);
      end
      mode(1'b1, 1'b1, 1'b0, 1'b0);
      rd(`CFE_OFF_TBSEL, 8'h00, 1'b0);
      wr(`CFE_OFF_TBSEL, 8'h07);
      rd(`CFE_OFF_TBSEL, 8'h00, 1'b0);
      win(1'b0);
      for (i = 0; i < 4; i++) begin
         wr(`CFE_OFF_IDAC, 8'hCF | 8'(i << 4));
         rd(`CFE_OFF_IDAC, 8'(i << 4) | {5'h0, hit}, 1'b0);
         chk("mode", 32'(i), {30'h0, acceptanceMode});
         h = 3'($random(seed));
         cfe_can_peer_i.send_msg(h);
         @(posedge mclk);
         chk("fgReload", 32'(i != ACC_CLOSED), {31'h0, fgReload});
         if (i != ACC_CLOSED) hit = h;
         rd(`CFE_OFF_IDAC, 8'(i << 4) | {5'h0, hit}, 1'b0);
      end
      wr(`CFE_OFF_RXERR, 8'hFF);
      rd(`CFE_OFF_RXERR, rxCnt, 1'b0);
      mode(1'b0, 1'b0, 1'b0, 1'b0);
      wr(`CFE_OFF_IDAC, 8'h00);
      rd(`CFE_OFF_IDAC, {5'h6, hit}, 1'b0);
      rd(`CFE_OFF_RXERR, 8'h00, 1'b1);
      rd(`CFE_OFF_TXERR, 8'h00, 1'b1);
      mode(1'b0, 1'b0, 1'b1, 1'b1);
      rd(`CFE_OFF_TXERR, txCnt, 1'b0);
      cfe_can_peer_i.enter_bus_off();
      rd(`CFE_OFF_MISC, 8'h00, 1'b0);
      wr(`CFE_OFF_CTRL, 8'h01);
      wr(`CFE_OFF_IRQSTAT, 8'h07);
      wr(`CFE_OFF_IRQMASK, 8'h01);
      waitChk("irq", 1'b0);
      cfe_can_peer_i.enter_bus_off();
      waitChk("busOffHeld", 1'b1);
      rd(`CFE_OFF_MISC, 8'h01, 1'b0);
      chk("irq", 32'h1, {31'h0, irq});
      wr(`CFE_OFF_MISC, 8'h00);
      rd(`CFE_OFF_MISC, 8'h01, 1'b0);
      wr(`CFE_OFF_MISC, 8'h01);
      k = 0;
      for (i = 0; i < 4; i++) begin
         @(posedge mclk);
         k += int'(recoveryRequest === 1'b1);
      end
      chk("recoveryRequest", 32'h1, 32'(k));
      rd(`CFE_OFF_MISC, 8'h00, 1'b0);
      wr(`CFE_OFF_IRQMASK, 8'h00);
      waitChk("irq", 1'b0);
      wr(`CFE_OFF_IRQMASK, 8'h01);
      waitChk("irq", 1'b1);
      wr(`CFE_OFF_IRQSTAT, 8'h01);
      waitChk("irq", 1'b0);
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
